/* File: hw/icit_pkg.sv */
// Purpose: Shared constants and types for the capture/interval timer
// Assumes: 32-bit Avalon-MM data, byte addresses, 8-bit registers
// Notes:   Registers sit in the low byte of each word
package icit_pkg;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [4:0] ICIT_OFS_MODE      = 5'h00;
  localparam logic [4:0] ICIT_OFS_FALL      = 5'h04;
  localparam logic [4:0] ICIT_OFS_RISE      = 5'h08;
  localparam logic [4:0] ICIT_OFS_PORT_MODE = 5'h0C;
  localparam logic [4:0] ICIT_OFS_IRQ       = 5'h10;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int ICIT_BIT_OVF_HIGH  = 7;
  localparam int ICIT_BIT_OVF_LOW   = 6;
  localparam int ICIT_BIT_SEL_INPUT = 0;
  localparam int ICIT_BIT_FILTER    = 1;
  localparam int ICIT_BIT_IRQ_REQ   = 0;
  localparam int ICIT_BIT_IRQ_EN    = 1;
  localparam logic [7:0] ICIT_RST_BYTE = 8'h00;
  localparam logic [7:0] ICIT_CNT_MAX  = 8'hFF;

  // ****************************************
  // Prescaler and filter counts
  // ****************************************
  localparam int ICIT_PRESCALE_W = 6;
  localparam logic [5:0] ICIT_DIV64_MASK = 6'h3F;
  localparam logic [5:0] ICIT_DIV32_MASK = 6'h1F;
  localparam logic [5:0] ICIT_DIV2_MASK  = 6'h01;
  localparam int ICIT_FILTER_STAGES = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       overflow_high_flag;
    logic       overflow_low_flag;
    logic       overflow_irq_enable;
    logic       capture_irq_edge_select;
    logic       counter_clear_sel_hi;
    logic       counter_clear_sel_lo;
    logic       clock_sel_hi;
    logic       clock_sel_lo;
  } icit_mode_type;

  typedef struct packed {
    logic       rise;
    logic       fall;
  } icit_edge_type;

  typedef enum logic [1:0] {
    ICIT_BUS_IDLE = 2'b01,
    ICIT_BUS_ACK  = 2'b10
  } icit_bus_state_type;

endpackage

/* File: hw/icit_noise_filter.sv */
// Purpose: Five-latch majority-free match filter for the capture input
// Assumes: sample_in is a one-cycle enable on the system clock
// Notes:   Output holds until all latches agree
`timescale 1ns/1ps
module icit_noise_filter #(
  parameter int STAGES = icit_pkg::ICIT_FILTER_STAGES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Sampling
  input  wire logic sample_in,
  input  wire logic data_in,
  // Result
  output logic      level_out
);
  import icit_pkg::*;

  logic [STAGES-1:0] latches;
  logic              primed;
  logic              all_high;
  logic              all_low;

  assign all_high = &latches;
  assign all_low  = ~|latches;

  // ****************************************
  // Latch chain
  // ****************************************
  // Preset high so five low samples are needed before the output settles
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      latches <= '1;
    else if (sample_in)
      latches <= {latches[STAGES-2:0], data_in};
  end

  // Preset latches match high at once; block that until a settled low
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      primed <= 1'b0;
    else if (all_low)
      primed <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      level_out <= 1'b0;
    else if (all_high && primed)
      level_out <= 1'b1;
    else if (all_low)
      level_out <= 1'b0;
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_filter_match;
    @(posedge clk_in) disable iff (!rst_n_in)
      $changed(level_out) |-> $past(all_high) || $past(all_low);
  endproperty
  a_filter_match: assert property (p_filter_match)
    else $error("filter output changed without all latches agreeing");

endmodule

/* File: hw/icit_timer.sv */
// Purpose: 8-bit input capture / interval timer with Avalon-MM registers
// Assumes: Pins synchronous to clk_in; watch clock sampled as a level
// Notes:   Counter is internal; only capture registers expose it
//
// Notes on behaviour
// - Wrap FF to 00 with capture level high sets overflow-high flag.
// - Wrap with capture level low, or in interval mode, sets overflow-low.
// - Flags set by hardware; write 0 after reading 1 clears; 1 ignored.
// - Overflow with overflow interrupt enable set raises the request flag.
// - Edge select bit picks rising (0) or falling (1) capture interrupts.
// - Rising edge copies counter to rise capture; falling to fall capture.
// - Capture edge matching edge select sets request flag; enable gates it.
// - Clear field: 00 none, 01 falling, 10 rising, 11 both edges.
// - Clock select: 00 div64, 01 div32, 10 div2, 11 watch clock div2.
// - Reset zeroes mode, counter and captures; counting starts on div64.
// - Capture input select 1 gives capture mode, 0 interval mode.
// - Interval mode counts selected clock; wrap sets low flag, and request if overflow interrupt enable set.
// - Filter shifts input through five latches; changes only on match.
// - Filter samples on system clock, or selected clock when enabled.
// - After reset filter output settles after five low samples.
// - Filtered strobes lag five samples; shorter pulses are rejected.
// - Unfiltered strobes come straight from input edges.
// - Toggling filter or input select may cause spurious capture edges.
// - Counter is not readable or writable over the bus.
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module icit_timer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Pins
  input  wire logic        capture_pin_in,
  input  wire logic        watch_clk_in,
  // Interrupt request to the controller
  output logic             irq_out
);
  import icit_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // Declarations
  // ****************************************
  icit_bus_state_type bus_state;
  icit_mode_type      mode;
  icit_edge_type      strobe;
  logic [7:0]  capture_counter;
  logic [7:0]  rise_capture_value;
  logic [7:0]  fall_capture_value;
  logic        capture_input_select;
  logic        filter_enable;
  logic        timer_irq_request_flag;
  logic        timer_irq_enable;
  logic        armed_high;
  logic        armed_low;
  logic [ICIT_PRESCALE_W-1:0] prescale;
  logic        watch_prev;
  logic        watch_half;
  logic        tick_64;
  logic        tick_32;
  logic        tick_2;
  logic        tick_w;
  logic        count_tick;
  logic        filt_level;
  logic        cap_level;
  logic        cap_prev;
  logic        clear_hit;
  logic        wrap;
  logic        set_high;
  logic        set_low;
  logic        irq_set;
  logic        bus_accept;
  logic        wr_ok;
  logic        rd_mode;
  logic [7:0]  next_byte;
  logic [7:0]  wr_byte;

  // ****************************************
  // Clock sources
  // ****************************************
  // Free-running from reset, so div64 is live at once
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      prescale <= '0;
    else
      prescale <= prescale + 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watch_prev <= 1'b0;
      watch_half <= 1'b0;
    end
    else
    begin
      watch_prev <= watch_clk_in;
      if (watch_prev && !watch_clk_in)
        watch_half <= !watch_half;
    end
  end

  assign tick_64 = (prescale & ICIT_DIV64_MASK) == ICIT_DIV64_MASK;
  assign tick_32 = (prescale & ICIT_DIV32_MASK) == ICIT_DIV32_MASK;
  assign tick_2  = (prescale & ICIT_DIV2_MASK) == ICIT_DIV2_MASK;
  assign tick_w  = watch_prev && !watch_clk_in && watch_half;

  always_comb
  begin
    case ({mode.clock_sel_hi, mode.clock_sel_lo})
      2'b00:   count_tick = tick_64;
      2'b01:   count_tick = tick_32;
      2'b10:   count_tick = tick_2;
      2'b11:   count_tick = tick_w;
      default: count_tick = tick_64;
    endcase
  end

  // ****************************************
  // Capture input path
  // ****************************************
  icit_noise_filter #(
    .STAGES (ICIT_FILTER_STAGES)
  ) u_filter (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n),
    .sample_in (filter_enable ? count_tick : 1'b1),
    .data_in   (capture_pin_in),
    .level_out (filt_level)
  );

  // Interval mode reads the input as low; switching modes may glitch
  assign cap_level = capture_input_select
                   & (filter_enable ? filt_level : capture_pin_in);

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      cap_prev <= 1'b0;
    else
      cap_prev <= cap_level;
  end

  assign strobe.rise = cap_level && !cap_prev;
  assign strobe.fall = !cap_level && cap_prev;

  // ****************************************
  // Counter and captures
  // ****************************************
  assign clear_hit = (strobe.rise && mode.counter_clear_sel_hi)
                   || (strobe.fall && mode.counter_clear_sel_lo);
  assign wrap      = count_tick && !clear_hit
                   && capture_counter == ICIT_CNT_MAX;
  assign set_high  = wrap && cap_prev;
  assign set_low   = wrap && !cap_prev;

  // No bus path reaches the counter
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      capture_counter <= ICIT_RST_BYTE;
    else if (clear_hit)
      capture_counter <= ICIT_RST_BYTE;
    else if (count_tick)
      capture_counter <= capture_counter + 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_capture_value <= ICIT_RST_BYTE;
      fall_capture_value <= ICIT_RST_BYTE;
    end
    else
    begin
      if (strobe.rise)
        rise_capture_value <= capture_counter;
      if (strobe.fall)
        fall_capture_value <= capture_counter;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  // Request seen -> waitrequest low next cycle -> taken at following edge
  assign bus_accept = bus_state == ICIT_BUS_ACK;
  assign wr_ok   = bus_accept && avs_write_in && avs_byteenable_in[0];
  assign wr_byte = avs_writedata_in[7:0];
  assign rd_mode = bus_accept && avs_read_in
                && avs_address_in == ICIT_OFS_MODE;

  always_comb
  begin
    case (avs_address_in)
      ICIT_OFS_MODE:      next_byte = mode;
      ICIT_OFS_FALL:      next_byte = fall_capture_value;
      ICIT_OFS_RISE:      next_byte = rise_capture_value;
      ICIT_OFS_PORT_MODE: next_byte = {6'h00, filter_enable,
                                       capture_input_select};
      ICIT_OFS_IRQ:       next_byte = {6'h00, timer_irq_enable,
                                       timer_irq_request_flag};
      default:            next_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_state           <= ICIT_BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end
    else
    begin
      case (bus_state)
        ICIT_BUS_IDLE:
        begin
          if (avs_read_in || avs_write_in)
          begin
            bus_state           <= ICIT_BUS_ACK;
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= {24'h00_0000, next_byte};
          end
        end
        ICIT_BUS_ACK:
        begin
          bus_state           <= ICIT_BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default:
        begin
          bus_state           <= ICIT_BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Mode register and flags
  // ****************************************
  // A read that returns 1 arms the clear; it disarms once the flag reads 0
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_high <= 1'b0;
      armed_low  <= 1'b0;
    end
    else
    begin
      if (rd_mode && avs_readdata_out[ICIT_BIT_OVF_HIGH])
        armed_high <= 1'b1;
      else if (!mode.overflow_high_flag)
        armed_high <= 1'b0;
      if (rd_mode && avs_readdata_out[ICIT_BIT_OVF_LOW])
        armed_low <= 1'b1;
      else if (!mode.overflow_low_flag)
        armed_low <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      mode <= ICIT_RST_BYTE;
    else
    begin
      if (wr_ok && avs_address_in == ICIT_OFS_MODE)
      begin
        mode.overflow_irq_enable     <= wr_byte[5];
        mode.capture_irq_edge_select <= wr_byte[4];
        mode.counter_clear_sel_hi    <= wr_byte[3];
        mode.counter_clear_sel_lo    <= wr_byte[2];
        mode.clock_sel_hi            <= wr_byte[1];
        mode.clock_sel_lo            <= wr_byte[0];
        if (armed_high && !wr_byte[ICIT_BIT_OVF_HIGH])
          mode.overflow_high_flag <= 1'b0;
        if (armed_low && !wr_byte[ICIT_BIT_OVF_LOW])
          mode.overflow_low_flag <= 1'b0;
      end
      // Hardware set wins over a clear in the same cycle
      if (set_high)
        mode.overflow_high_flag <= 1'b1;
      if (set_low)
        mode.overflow_low_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_input_select <= 1'b0;
      filter_enable        <= 1'b0;
    end
    else if (wr_ok && avs_address_in == ICIT_OFS_PORT_MODE)
    begin
      capture_input_select <= wr_byte[ICIT_BIT_SEL_INPUT];
      filter_enable        <= wr_byte[ICIT_BIT_FILTER];
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  assign irq_set = ((set_high || set_low) && mode.overflow_irq_enable)
    || (mode.capture_irq_edge_select ? strobe.fall : strobe.rise);

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_irq_request_flag <= 1'b0;
      timer_irq_enable       <= 1'b0;
    end
    else
    begin
      if (wr_ok && avs_address_in == ICIT_OFS_IRQ)
      begin
        timer_irq_enable <= wr_byte[ICIT_BIT_IRQ_EN];
        if (!wr_byte[ICIT_BIT_IRQ_REQ])
          timer_irq_request_flag <= 1'b0;
      end
      if (irq_set)
        timer_irq_request_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      irq_out <= 1'b0;
    else
      irq_out <= timer_irq_request_flag && timer_irq_enable;
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_wrap_high;
    wrap && cap_prev;
  endsequence

  sequence s_wrap_low;
    wrap && !cap_prev;
  endsequence

  property p_ovf_high;
    @(posedge clk_in) disable iff (!rst_n)
      s_wrap_high |=> mode.overflow_high_flag;
  endproperty
  a_ovf_high: assert property (p_ovf_high)
    else $error("high overflow did not set the high flag");

  property p_ovf_low;
    @(posedge clk_in) disable iff (!rst_n)
      s_wrap_low ##1 1'b1 |-> mode.overflow_low_flag && capture_counter == 8'h00;
  endproperty
  a_ovf_low: assert property (p_ovf_low)
    else $error("low overflow did not set the low flag");

  property p_write_one_ignored;
    @(posedge clk_in) disable iff (!rst_n)
      !mode.overflow_low_flag && !set_low ##0 wr_ok
      && avs_address_in == ICIT_OFS_MODE |=> !mode.overflow_low_flag;
  endproperty
  a_write_one_ignored: assert property (p_write_one_ignored)
    else $error("software write set an overflow flag");

  property p_ovf_irq;
    @(posedge clk_in) disable iff (!rst_n)
      (set_high || set_low) && mode.overflow_irq_enable
      |=> timer_irq_request_flag ##1 (irq_out == timer_irq_enable
          || $changed(timer_irq_enable));
  endproperty
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("overflow interrupt request missing");

  property p_edge_irq;
    @(posedge clk_in) disable iff (!rst_n)
      (mode.capture_irq_edge_select ? strobe.fall : strobe.rise)
      |=> timer_irq_request_flag;
  endproperty
  a_edge_irq: assert property (p_edge_irq)
    else $error("selected capture edge did not request");

  property p_rise_capture;
    @(posedge clk_in) disable iff (!rst_n)
      strobe.rise |=> rise_capture_value == $past(capture_counter);
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("rising capture value wrong");

  property p_fall_capture;
    @(posedge clk_in) disable iff (!rst_n)
      strobe.fall |=> fall_capture_value == $past(capture_counter);
  endproperty
  a_fall_capture: assert property (p_fall_capture)
    else $error("falling capture value wrong");

  property p_clear;
    @(posedge clk_in) disable iff (!rst_n)
      strobe.fall && mode.counter_clear_sel_lo
      |=> capture_counter == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter not cleared on falling edge");

  property p_hold;
    @(posedge clk_in) disable iff (!rst_n)
      !count_tick && !clear_hit |=> $stable(capture_counter);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved without its selected clock");

endmodule

/* File: testbench/icit_pulse_source.sv */
// Purpose: Behavioural pulse source driving the capture pin
// Assumes: Called from the bench right after a rising clock edge
// Notes:   Levels shorter than two cycles are stretched, never shortened
`timescale 1ns/1ps
module icit_pulse_source (
  // Clock
  input  wire logic clk_in,
  // Pin
  output logic      pin_out
);
  initial pin_out = 1'b0;

  // Hold one level for a number of system clock cycles
  task automatic drive(input logic lvl, input int cycles);
    int n;
    n = (cycles < 2) ? 2 : cycles;
    @(posedge clk_in);
    pin_out <= lvl;
    repeat (n) @(posedge clk_in);
  endtask
endmodule

/* File: testbench/icit_timer_tb.sv */
// Purpose: Self-checking bench for the capture/interval timer
// Assumes: Bus answers within fifty cycles
// Notes:   Counter figures allow one count of prescaler phase slack
`timescale 1ns/1ps
module icit_timer_tb;
  import icit_pkg::*;
  logic        clk_in;
  logic        arst_n_in;
  logic [4:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        capture_pin_in;
  logic        watch_clk_in;
  logic        irq_out;
  int          err_total;
  int          tests_run;
  int          i;
  logic [31:0] rd;
  int          div_exp [4] = '{3, 6, 100, 12};
  logic [4:0]  ofs [6] = '{ICIT_OFS_MODE, ICIT_OFS_FALL, ICIT_OFS_RISE,
                            ICIT_OFS_PORT_MODE, ICIT_OFS_IRQ, 5'h14};

  icit_timer dut (
    .clk_in              (clk_in),
    .arst_n_in           (arst_n_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .capture_pin_in      (capture_pin_in),
    .watch_clk_in        (watch_clk_in),
    .irq_out             (irq_out)
  );

  icit_pulse_source src (
    .clk_in  (clk_in),
    .pin_out (capture_pin_in)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Watch clock: one fall every eight system cycles
  initial
  begin
    watch_clk_in = 1'b0;
    forever
    begin
      repeat (4) @(posedge clk_in);
      watch_clk_in <= ~watch_clk_in;
    end
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] near(input logic [31:0] s, input int e);
    return {31'h0, (s >= e - 1) && (s <= e + 1)};
  endfunction

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [4:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge clk_in);
    avs_address_in    <= a;
    avs_writedata_in  <= {24'h000000, d};
    avs_byteenable_in <= be;
    avs_read_in       <= ~wr_en;
    avs_write_in      <= wr_en;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      wrap_up();
    end
    rd = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdchk(input string what, input logic [4:0] a,
                       input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    check(what, rd, {24'h000000, exp});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    arst_n_in         = 1'b0;
    avs_address_in    = 5'h00;
    avs_read_in       = 1'b0;
    avs_write_in      = 1'b0;
    avs_writedata_in  = 32'h00000000;
    avs_byteenable_in = 4'h0;
    err_total         = 0;
    tests_run         = 0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    foreach (ofs[k]) rdchk("reset value", ofs[k], ICIT_RST_BYTE);
    wr(ICIT_OFS_MODE, 8'hC0);
    rdchk("flag set by write", ICIT_OFS_MODE, 8'h00);
    bus(1'b1, ICIT_OFS_MODE, 8'h3C, 4'h0);
    rdchk("lane disabled", ICIT_OFS_MODE, 8'h00);
    wr(ICIT_OFS_RISE, 8'hFF);
    rdchk("read only", ICIT_OFS_RISE, 8'h00);
    wr(5'h14, 8'h5A);
    rdchk("unmapped", 5'h14, 8'h00);
    // Count rate per clock select, counter cleared on rising edge
    wr(ICIT_OFS_PORT_MODE, 8'h01);
    for (i = 0; i < 4; i++)
    begin
      wr(ICIT_OFS_MODE, 8'h08 | i[7:0]);
      src.drive(1'b0, 4);
      src.drive(1'b1, 200);
      src.drive(1'b0, 4);
      bus(1'b0, ICIT_OFS_FALL, 8'h00, 4'hF);
      check("fall capture", near(rd, div_exp[i]), 32'h1);
    end
    // Clear field codes at div2
    for (i = 1; i < 4; i++)
    begin
      wr(ICIT_OFS_MODE, {4'h0, i[1:0], 2'b10});
      src.drive(1'b0, 4);
      src.drive(1'b1, 200);
      src.drive(1'b0, 100);
      src.drive(1'b1, 4);
      src.drive(1'b0, 4);
      bus(1'b0, ICIT_OFS_RISE, 8'h00, 4'hF);
      check("rise capture", near(rd, (i == 2) ? 150 : 50), 32'h1);
    end
    // Capture interrupt edge select
    for (i = 0; i < 2; i++)
    begin
      wr(ICIT_OFS_MODE, {3'b000, i[0], 4'b0010});
      wr(ICIT_OFS_IRQ, 8'h00);
      src.drive(1'b1, 10);
      rdchk("rise request", ICIT_OFS_IRQ, {7'h00, ~i[0]});
      wr(ICIT_OFS_IRQ, 8'h00);
      src.drive(1'b0, 10);
      rdchk("fall request", ICIT_OFS_IRQ, {7'h00, i[0]});
    end
    check("masked irq", {31'h0, irq_out}, 32'h0);
    wr(ICIT_OFS_IRQ, 8'h03);
    rdchk("request kept", ICIT_OFS_IRQ, 8'h03);
    check("irq line", {31'h0, irq_out}, 32'h1);
    wr(ICIT_OFS_IRQ, 8'h02);
    rdchk("request cleared", ICIT_OFS_IRQ, 8'h02);
    check("irq released", {31'h0, irq_out}, 32'h0);
    // Short pulse passes raw path, filter rejects it
    wr(ICIT_OFS_MODE, 8'h02);
    for (i = 0; i < 2; i++)
    begin
      wr(ICIT_OFS_PORT_MODE, {6'h00, i[0], 1'b1});
      src.drive(1'b0, 40);
      wr(ICIT_OFS_IRQ, 8'h00);
      src.drive(1'b1, 6);
      src.drive(1'b0, 30);
      rdchk("short pulse", ICIT_OFS_IRQ, {7'h00, ~i[0]});
      src.drive(1'b1, 30);
      rdchk("long pulse", ICIT_OFS_IRQ, 8'h01);
      src.drive(1'b0, 30);
    end
    // Interval mode overflow, with and without overflow interrupt
    wr(ICIT_OFS_PORT_MODE, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      wr(ICIT_OFS_IRQ, 8'h00);
      bus(1'b0, ICIT_OFS_MODE, 8'h00, 4'hF);
      wr(ICIT_OFS_MODE, {2'b00, i[0], 5'b00010});
      repeat (600) @(posedge clk_in);
      rdchk("overflow request", ICIT_OFS_IRQ, {7'h00, i[0]});
      wr(ICIT_OFS_MODE, {2'b00, i[0], 5'b00010});
      rdchk("low flag", ICIT_OFS_MODE, {2'b01, i[0], 5'b00010});
      wr(ICIT_OFS_MODE, {2'b00, i[0], 5'b00000});
      rdchk("flag cleared", ICIT_OFS_MODE, {2'b00, i[0], 5'b00000});
    end
    // Wrap while the capture level is high
    wr(ICIT_OFS_PORT_MODE, 8'h01);
    bus(1'b0, ICIT_OFS_MODE, 8'h00, 4'hF);
    wr(ICIT_OFS_MODE, 8'h02);
    src.drive(1'b1, 600);
    rdchk("high flag", ICIT_OFS_MODE, 8'h82);
    src.drive(1'b0, 4);
    wrap_up();
  end
endmodule
